// [rtl/sfc_config_control.sv]
// Configuration loading, initialization and user-mode control.
// Assumes all inputs but the asynchronous rst_b synchronous to ref_clk; pads resolve pull-ups and
// high impedance from the enables driven here.
`timescale 1ns/10ps

// Overview of operation
// - Logic stays off after power-up until a complete configuration load finishes.
// - After loading, initialize: hold core registers in reset, then enable I/O and run in the same cycle.
// - I/O pins stay high impedance through power-up and configuration load.
// - Weak pull-up is enabled on user I/O before and during configuration.
// - Command state covers load and initialization; user state follows only afterwards.
// - Asserting the reconfigure pin returns to command state, reloads, reinitializes, resumes.
// - Configuration data accepted through any of five load schemes.
// - Chain enable in gates loading; chain enable out passes ownership onward.
// - Byte-wide load at 40 MHz completes well under 100 ms.
// - Host may load serially or in parallel, clocked or by handshake.
// - Host writes configuration bytes to one virtual memory location.
// - PLL counter settings reload through a serial chain from logic or pins.
// - PLL chain reload leaves all other logic running normally.
// - Identification word is version, part number, maker field and a one bit.
// - Identification word least significant bit always reads one.
module sfc_config_control
	import sfc_pkg::*;
#(
	parameter int IMAGE_LEN = IMAGE_BYTES,
	parameter int LOAD_LIMIT = LOAD_LIMIT_CYCLES,
	parameter int PLL_BITS = PLL_CHAIN_BITS,
	parameter logic [ID_VER_W-1:0] ID_VERSION = ID_VER_DEF,
	parameter logic [ID_PART_W-1:0] ID_PART = ID_PART_DEF,
	parameter logic [ID_MAKER_W-1:0] ID_MAKER = ID_MAKER_DEF
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic reconfig_n,
	input wire logic chain_enable_in_n,
	output logic chain_enable_out_n,
	input sfc_scheme_t scheme,
	input wire logic serialData,
	input wire logic serialStrobe,
	input wire logic [7:0] parallelData,
	input wire logic parallelStrobe,
	input wire logic hostWrite_n,
	input wire logic hostChipSel_n,
	input wire logic [7:0] hostData,
	output logic hostReady,
	input wire logic scanLoadBit,
	input wire logic scanLoadStrobe,
	output logic ioOutEnable,
	output logic ioPullUpEnable,
	output logic coreReset_n,
	output logic coreRun,
	output logic [ID_VER_W+ID_PART_W+ID_MAKER_W:0] identification_word,
	output sfc_status_t status,
	input wire logic pllChainSel,
	input wire logic pllShiftLogic,
	input wire logic pllDataLogic,
	input wire logic pllShiftPin,
	input wire logic pllDataPin,
	input wire logic pllUpdate,
	output logic [PLL_BITS-1:0] pllSettings,
	output logic pllBusy
);

	localparam int IMG_W = $clog2(IMAGE_LEN + 1);
	localparam int LIM_W = $clog2(LOAD_LIMIT + 1);
	localparam int INIT_W = $clog2(INIT_CYCLES + 1);

	typedef struct packed {
		sfc_state_t state;
		logic [IMG_W-1:0] byteCount;
		logic [IMG_W-1:0] pushCount;
		logic [LIM_W-1:0] loadTimer;
		logic [INIT_W-1:0] initTimer;
		logic [7:0] shiftByte;
		logic [2:0] bitCount;
		logic hostWrPrev;
		logic reconfigPrev;
		logic slowLoad;
		logic [PLL_BITS-1:0] pllShift;
		logic [PLL_BITS-1:0] pllActive;
		logic pllShifting;
	} sfc_ctl_state_t;

	sfc_ctl_state_t st_q, st_d;
	sfc_beat_t srcBeat, sinkBeat;
	logic srcValid, srcReady, sinkValid, sinkReady;
	logic inLoad, flushBuf;
	logic pllShift, pllBit;

	// ----------------------------------------------------------------
	// Source selection per load scheme
	// ----------------------------------------------------------------
	// Serial schemes assemble bytes msb first; parallel ones pass bytes.
	always_comb begin
		srcValid = 1'b0;
		srcBeat.data = parallelData;
		// Marked from bytes pushed, so back-to-back bytes cannot shift the mark
		srcBeat.last = (st_q.pushCount == IMG_W'(IMAGE_LEN - 1));
		unique case (scheme)
			SFC_SCHEME_CFG_MEMORY, SFC_SCHEME_PASSIVE_SERIAL, SFC_SCHEME_BOUNDARY_SCAN: begin
				srcBeat.data = {st_q.shiftByte[6:0], (scheme == SFC_SCHEME_BOUNDARY_SCAN) ? scanLoadBit : serialData};
				srcValid = ((scheme == SFC_SCHEME_BOUNDARY_SCAN) ? scanLoadStrobe : serialStrobe)
					&& (st_q.bitCount == 3'h7);
			end
			SFC_SCHEME_FAST_PARALLEL: begin
				srcValid = parallelStrobe;
			end
			SFC_SCHEME_PARALLEL_ASYNC: begin
				// Write taken on the first low sample of the write strobe
				srcBeat.data = hostData;
				srcValid = !hostWrite_n && st_q.hostWrPrev && !hostChipSel_n;
			end
			default: begin
				srcValid = 1'b0;
			end
		endcase
		srcValid = srcValid && inLoad;
	end

	assign inLoad = (st_q.state == SFC_ST_LOAD) && !chain_enable_in_n;
	assign flushBuf = (st_q.state != SFC_ST_LOAD);
	assign hostReady = srcReady && inLoad;
	assign sinkReady = inLoad;

	// ----------------------------------------------------------------
	// Buffer between pins and loader
	// ----------------------------------------------------------------
	sfc_skid_buffer #(
		.DEPTH(2)
	) i_sfc_skid_buffer (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.inValid(srcValid),
		.inReady(srcReady),
		.inBeat(srcBeat),
		.outValid(sinkValid),
		.outReady(sinkReady),
		.outBeat(sinkBeat),
		.flush(flushBuf)
	);

	// ----------------------------------------------------------------
	// PLL serial chain, independent of mode
	// ----------------------------------------------------------------
	assign pllShift = pllChainSel ? pllShiftPin : pllShiftLogic;
	assign pllBit = pllChainSel ? pllDataPin : pllDataLogic;

	// ----------------------------------------------------------------
	// Main sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.hostWrPrev = hostWrite_n;
		st_d.reconfigPrev = reconfig_n;
		// Serial bit gather; holds its value outside loading
		if (inLoad && srcReady) begin
			if ((scheme == SFC_SCHEME_BOUNDARY_SCAN && scanLoadStrobe) ||
				(scheme != SFC_SCHEME_BOUNDARY_SCAN && serialStrobe)) begin
				st_d.shiftByte = srcBeat.data;
				st_d.bitCount = st_q.bitCount + 3'h1;
			end
		end
		// Count bytes entering the buffer for the last-byte mark
		if (srcValid && srcReady) begin
			st_d.pushCount = st_q.pushCount + 1'b1;
		end
		// Chain shifts never touch the sequencer, so user logic keeps running
		st_d.pllShifting = pllShift;
		if (pllShift) begin
			st_d.pllShift = {st_q.pllShift[PLL_BITS-2:0], pllBit};
		end
		if (pllUpdate) begin
			st_d.pllActive = st_q.pllShift;
		end
		unique case (st_q.state)
			SFC_ST_WAIT_CHAIN: begin
				// Wait for ownership from the previous chain member
				if (!chain_enable_in_n) begin
					st_d.state = SFC_ST_LOAD;
				end
			end
			SFC_ST_LOAD: begin
				if (inLoad && st_q.loadTimer != LIM_W'(LOAD_LIMIT)) begin
					st_d.loadTimer = st_q.loadTimer + 1'b1;
				end
				if (st_q.loadTimer == LIM_W'(LOAD_LIMIT)) begin
					st_d.slowLoad = 1'b1;
				end
				if (sinkValid && sinkReady) begin
					st_d.byteCount = st_q.byteCount + 1'b1;
					if (sinkBeat.last) begin
						st_d.state = SFC_ST_INIT;
						st_d.initTimer = '0;
					end
				end
				if (chain_enable_in_n && st_q.byteCount != '0) begin
					st_d.state = SFC_ST_ERROR; // Ownership lost mid-load
				end
			end
			SFC_ST_INIT: begin
				st_d.initTimer = st_q.initTimer + 1'b1;
				if (st_q.initTimer == INIT_W'(INIT_CYCLES - 1)) begin
					st_d.state = SFC_ST_USER;
				end
			end
			SFC_ST_USER, SFC_ST_ERROR: begin
			end
			default: begin
				st_d.state = SFC_ST_ERROR;
			end
		endcase
		// Falling edge of reconfigure pin restarts the whole command state
		if (!reconfig_n && st_q.reconfigPrev) begin
			st_d.state = SFC_ST_WAIT_CHAIN;
			st_d.byteCount = '0;
			st_d.pushCount = '0;
			st_d.loadTimer = '0;
			st_d.bitCount = '0;
			st_d.slowLoad = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
			st_q.state <= SFC_ST_WAIT_CHAIN;
			st_q.hostWrPrev <= 1'b1;
			st_q.reconfigPrev <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// I/O drive only in user state; pull-ups through whole command state
	assign ioOutEnable = (st_q.state == SFC_ST_USER);
	assign ioPullUpEnable = (st_q.state != SFC_ST_USER);
	assign coreReset_n = (st_q.state == SFC_ST_USER);
	assign coreRun = (st_q.state == SFC_ST_USER);
	// Pass ownership once this device is done loading
	assign chain_enable_out_n = !(st_q.state == SFC_ST_INIT || st_q.state == SFC_ST_USER);
	assign identification_word = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
	assign status.commandMode = (st_q.state != SFC_ST_USER);
	assign status.userMode = (st_q.state == SFC_ST_USER);
	assign status.loadDone = (st_q.state == SFC_ST_INIT || st_q.state == SFC_ST_USER);
	assign status.loadError = (st_q.state == SFC_ST_ERROR);
	assign status.slowLoad = st_q.slowLoad;
	assign pllSettings = st_q.pllActive;
	assign pllBusy = st_q.pllShifting;

endmodule : sfc_config_control

// [rtl/sfc_pkg.sv]
// Shared types and constants for the configuration control block.
// Assumes one 40 MHz clock domain and an active-low asynchronous reset.
package sfc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int INIT_TIME_NS = 1000;
	localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOAD_LIMIT_MS = 100;
	// Cycles per millisecond first, so no intermediate product overflows an int
	localparam int LOAD_LIMIT_CYCLES = LOAD_LIMIT_MS * (1000000 / CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// Image and chain sizes
	// ----------------------------------------------------------------
	localparam int IMAGE_BYTES = 4096;
	localparam int PLL_CHAIN_BITS = 36;

	// ----------------------------------------------------------------
	// Identification word layout, msb leftmost
	// ----------------------------------------------------------------
	localparam int ID_VER_W = 4;
	localparam int ID_PART_W = 16;
	localparam int ID_MAKER_W = 11;
	localparam logic ID_LSB = 1'h1;
	// Arbitrary neutral identity values
	localparam logic [ID_VER_W-1:0] ID_VER_DEF = 4'h1;
	localparam logic [ID_PART_W-1:0] ID_PART_DEF = 16'h1234;
	localparam logic [ID_MAKER_W-1:0] ID_MAKER_DEF = 11'h055;

	// ----------------------------------------------------------------
	// Load schemes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SFC_SCHEME_CFG_MEMORY,
		SFC_SCHEME_PASSIVE_SERIAL,
		SFC_SCHEME_PARALLEL_ASYNC,
		SFC_SCHEME_FAST_PARALLEL,
		SFC_SCHEME_BOUNDARY_SCAN
	} sfc_scheme_t;

	typedef enum logic [2:0] {
		SFC_ST_WAIT_CHAIN,
		SFC_ST_LOAD,
		SFC_ST_INIT,
		SFC_ST_USER,
		SFC_ST_ERROR
	} sfc_state_t;

	// One configuration byte on its way to the loader
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} sfc_beat_t;

	// Status seen outside
	typedef struct packed {
		logic commandMode;
		logic userMode;
		logic loadDone;
		logic loadError;
		logic slowLoad;
	} sfc_status_t;

endpackage : sfc_pkg

// [rtl/sfc_skid_buffer.sv]
// Two-entry valid/ready buffer carrying configuration beats.
// Assumes both sides run on ref_clk; full and empty are exact.
`timescale 1ns/10ps
module sfc_skid_buffer
	import sfc_pkg::*;
#(
	parameter int DEPTH = 2
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic inValid,
	output logic inReady,
	input sfc_beat_t inBeat,
	output logic outValid,
	input wire logic outReady,
	output sfc_beat_t outBeat,
	input wire logic flush
);

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] wrPtr;
		logic [PW-1:0] rdPtr;
		logic [PW:0] count;
	} sfc_buf_state_t;

	sfc_beat_t mem_q [DEPTH];
	sfc_buf_state_t st_q, st_d;
	logic push, pop;

	// ----------------------------------------------------------------
	// Handshakes
	// ----------------------------------------------------------------
	assign inReady = (st_q.count != (PW+1)'(DEPTH)) && !flush;
	assign outValid = (st_q.count != '0);
	assign outBeat = mem_q[st_q.rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Pointer and occupancy update; flush drops stale beats on restart
	always_comb begin
		st_d = st_q;
		if (flush) begin
			st_d = '0;
		end else begin
			if (push) begin
				st_d.wrPtr = (st_q.wrPtr == PW'(DEPTH-1)) ? '0 : st_q.wrPtr + 1'b1;
			end
			if (pop) begin
				st_d.rdPtr = (st_q.rdPtr == PW'(DEPTH-1)) ? '0 : st_q.rdPtr + 1'b1;
			end
			st_d.count = st_q.count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Storage has no reset; contents are only read when counted valid
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[st_q.wrPtr] <= inBeat;
		end
	end

endmodule : sfc_skid_buffer

// [test/sfc_config_checker.sv]
// Port-level checks for the configuration control block.
// Assumes one ref_clk domain; attached by the bind at the foot.
`timescale 1ns/10ps
module sfc_config_checker
	import sfc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic reconfig_n,
	input wire logic chain_enable_out_n,
	input wire logic ioOutEnable,
	input wire logic ioPullUpEnable,
	input wire logic coreReset_n,
	input wire logic coreRun,
	input wire logic [ID_VER_W+ID_PART_W+ID_MAKER_W:0] identification_word,
	input sfc_status_t status
);
	// One domain, so clock and reset are stated once
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	AST_IO_HIZ: assert property (status.commandMode |-> !ioOutEnable) else $error("pins driven");
	AST_PULL_UP: assert property (status.commandMode |-> ioPullUpEnable) else $error("pull-up off");
	AST_RUN_USER: assert property (coreRun |-> status.userMode) else $error("run outside user");
	AST_CHAIN_OUT: assert property (status.userMode |-> !chain_enable_out_n) else $error("chain out high");
	AST_RESTART: assert property ($fell(reconfig_n) |-> ##[1:2] status.commandMode)
		else $error("no restart");
	AST_USER_ENTRY: assert property ($rose(status.userMode) |-> coreReset_n && ioOutEnable && coreRun)
		else $error("bad user entry");
	// Init lasts exactly INIT_CYCLES cycles between loading and user mode
	AST_INIT_SPAN: assert property ($rose(status.userMode) |->
		$past(status.loadDone && status.commandMode, INIT_CYCLES) && !$past(status.loadDone, INIT_CYCLES + 1))
		else $error("wrong init span");
	AST_ID_WORD: assert property (identification_word[31:1] == {ID_VER_DEF, ID_PART_DEF, ID_MAKER_DEF})
		else $error("bad id fields");
	AST_ID_LSB: assert property (identification_word[0] == ID_LSB) else $error("id lsb low");
endmodule : sfc_config_checker

bind sfc_config_control sfc_config_checker i_sfc_config_checker (.ref_clk, .rst_b, .reconfig_n,
	.chain_enable_out_n, .ioOutEnable, .ioPullUpEnable, .coreReset_n, .coreRun, .identification_word, .status);

// [test/sfc_cfg_source.sv]
// Download source model: feeds image bytes in the selected scheme.
// Assumes hostReady from the device gates every bit or byte offered.
`timescale 1ns/10ps
module sfc_cfg_source
	import sfc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic go,
	input wire logic [3:0] byteCount,
	input wire logic [31:0] seed,
	input sfc_scheme_t scheme,
	input wire logic hostReady,
	output logic serialData,
	output logic serialStrobe,
	output logic [7:0] parallelData,
	output logic parallelStrobe,
	output logic [7:0] hostData,
	output logic hostWrite_n,
	output logic hostChipSel_n,
	output logic scanLoadBit,
	output logic scanLoadStrobe,
	output logic busy
);
	logic [31:0] r;
	// Offer a unit only while the device can take it, so nothing is dropped
	task automatic ready();
		@(negedge ref_clk);
		while (!hostReady)
			@(negedge ref_clk);
	endtask : ready
	// Released lines show the inverse of their last value
	task automatic send(input logic [7:0] b);
		case (scheme)
			SFC_SCHEME_FAST_PARALLEL: begin
				ready();
				{parallelStrobe, parallelData} = {1'b1, b};
				@(negedge ref_clk);
				{parallelStrobe, parallelData} = {1'b0, ~b};
			end
			SFC_SCHEME_PARALLEL_ASYNC: begin
				ready();
				{hostChipSel_n, hostWrite_n, hostData} = {2'h0, b};
				@(negedge ref_clk);
				{hostChipSel_n, hostWrite_n, hostData} = {2'h3, ~b};
			end
			default: for (int i = 7; i >= 0; i--) begin
				ready();
				if (scheme == SFC_SCHEME_BOUNDARY_SCAN)
					{scanLoadStrobe, scanLoadBit} = {1'b1, b[i]};
				else
					{serialStrobe, serialData} = {1'b1, b[i]};
				@(negedge ref_clk);
				{serialStrobe, scanLoadStrobe} = 2'h0;
				{serialData, scanLoadBit} = ~{serialData, scanLoadBit};
			end
		endcase
	endtask : send
	// Byte values from a small shift register seeded by the bench
	initial begin
		{serialData, serialStrobe, parallelStrobe, scanLoadBit, scanLoadStrobe, busy} = 6'h00;
		{hostWrite_n, hostChipSel_n, parallelData, hostData} = 18'h3ffff;
		forever begin
			@(posedge go);
			busy = 1'b1;
			r = seed;
			for (int n = 0; n < byteCount; n++) begin
				r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
				send(r[7:0]);
			end
			busy = 1'b0;
		end
	end
endmodule : sfc_cfg_source

// [test/sfc_config_control_bench.sv]
// Self-checking bench: every load scheme, a broken load, both PLL chain paths.
// Assumes the design, the checker bind and the source model compile first.
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module sfc_config_control_bench
	import sfc_pkg::*;
();
	localparam int IMG = 8;
	logic ref_clk, rst_b, reconfig_n, chain_enable_in_n, chain_enable_out_n, seenUser, seenErr;
	logic serialData, serialStrobe, parallelStrobe, hostWrite_n, hostChipSel_n, hostReady;
	logic scanLoadBit, scanLoadStrobe, ioOutEnable, ioPullUpEnable, coreReset_n, coreRun, pllBusy;
	logic pllChainSel, pllShiftLogic, pllDataLogic, pllShiftPin, pllDataPin, pllUpdate, srcGo, srcBusy;
	logic [7:0] parallelData, hostData;
	logic [31:0] identification_word, rng, srcSeed;
	logic [PLL_CHAIN_BITS-1:0] pllSettings, pllExp;
	logic [3:0] srcCount;
	logic [2:0] e;
	logic [2:0] expQ[$];
	sfc_scheme_t scheme;
	sfc_status_t status;
	int fail_count, checks_done;

	sfc_config_control #(.IMAGE_LEN(IMG), .LOAD_LIMIT(50)) i_sfc_config_control (.ref_clk, .rst_b, .reconfig_n,
		.chain_enable_in_n, .chain_enable_out_n, .scheme, .serialData, .serialStrobe, .parallelData,
		.parallelStrobe, .hostWrite_n, .hostChipSel_n, .hostData, .hostReady, .scanLoadBit, .scanLoadStrobe,
		.ioOutEnable, .ioPullUpEnable, .coreReset_n, .coreRun, .identification_word, .status, .pllChainSel,
		.pllShiftLogic, .pllDataLogic, .pllShiftPin, .pllDataPin, .pllUpdate, .pllSettings, .pllBusy);
	sfc_cfg_source i_sfc_cfg_source (.ref_clk, .go(srcGo), .byteCount(srcCount), .seed(srcSeed), .scheme,
		.hostReady, .serialData, .serialStrobe, .parallelData, .parallelStrobe, .hostData, .hostWrite_n,
		.hostChipSel_n, .scanLoadBit, .scanLoadStrobe, .busy(srcBusy));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic tick();
		@(negedge ref_clk);
	endtask : tick
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// One image, full or short, after an optional restart pulse
	task automatic load(input int s, input int n, input bit pulse);
		scheme = sfc_scheme_t'(s);
		chain_enable_in_n = 1'b0;
		if (pulse) begin
			reconfig_n = 1'b0;
			tick();
			reconfig_n = 1'b1;
		end
		repeat (2) tick();
		if (n == IMG)
			expQ.push_back(3'b110);
		rng = xs(rng);
		srcSeed = rng;
		srcCount = 4'(n);
		srcGo = 1'b1;
		tick();
		srcGo = 1'b0;
		for (int w = 0; w < 900 && (srcBusy || (n == IMG && !status.userMode)); w++)
			tick();
	endtask : load

	// Oldest note is matched when user mode or a load error first shows
	always @(negedge ref_clk) begin
		if (rst_b && ((status.userMode && !seenUser) || (status.loadError && !seenErr))) begin
			e = expQ.size() ? expQ.pop_front() : 3'h7;
			`CHK({ioOutEnable, coreRun, chain_enable_out_n}, e)
		end
		seenUser = status.userMode;
		seenErr = status.loadError;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		close_out();
	end

	initial begin
		{rst_b, srcGo, pllChainSel, pllShiftLogic, pllDataLogic, pllShiftPin, pllDataPin, pllUpdate} = 8'h00;
		{reconfig_n, chain_enable_in_n, seenUser, seenErr, srcSeed, srcCount} = {4'hc, 36'h0};
		scheme = SFC_SCHEME_CFG_MEMORY;
		{rng, fail_count, checks_done} = {32'h00017839, 64'h0};
		repeat (2) tick();
		rst_b = 1'b1;
		`CHK({ioOutEnable, ioPullUpEnable, coreRun, chain_enable_out_n}, 4'h5)
		`CHK(identification_word, {ID_VER_DEF, ID_PART_DEF, ID_MAKER_DEF, 1'h1})
		// Slow serial loads overrun the shortened limit; byte-wide ones do not
		for (int s = 0; s < 5; s++) begin
			load(s, IMG, s != 0);
			`CHK({status.userMode, status.slowLoad}, {1'b1, s inside {0, 1, 4}})
		end
		load(3, IMG - 1, 1'b1);
		repeat (60) tick();
		`CHK({status.userMode, status.loadDone, chain_enable_out_n}, 3'h1)
		expQ.push_back(3'b001);
		chain_enable_in_n = 1'b1;
		repeat (4) tick();
		`CHK(status.loadError, 1'b1)
		load(1, IMG, 1'b1);
		`CHK(status.loadError, 1'b0)
		for (int via = 0; via < 2; via++) begin
			pllChainSel = via[0];
			for (int i = 0; i < PLL_CHAIN_BITS; i++) begin
				rng = xs(rng);
				pllExp = {pllExp[PLL_CHAIN_BITS-2:0], rng[0]};
				// Unselected path shifts the inverse, so a wrong select shows
				{pllShiftPin, pllDataPin, pllShiftLogic, pllDataLogic} = via ? {1'b1, rng[0], 1'b1, ~rng[0]}
					: {1'b1, ~rng[0], 1'b1, rng[0]};
				tick();
				`CHK({pllBusy, status.userMode}, 2'h3)
			end
			{pllShiftPin, pllShiftLogic} = 2'h0;
			pllUpdate = 1'b1;
			tick();
			pllUpdate = 1'b0;
			tick();
			`CHK({pllSettings, pllBusy, status.userMode, coreRun}, {pllExp, 3'h3})
		end
		`CHK(expQ.size() == 0, 1'b1)
		close_out();
	end
endmodule : sfc_config_control_bench
